// ### design/nmiss_top.sv
// nmiss_top: nmi source, status and mask ports of the peripheral controller
// assumes a host i/o cycle is one sys_clk pulse of io_wr_stb or io_rd_stb with
// a stable address; timer outputs, refresh strobe and pins are asynchronous
`timescale 1ns/10ps
module nmiss_top
    import nmiss_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [nmiss_pkg::NMISS_ADDR_W-1:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr_stb,
    input wire logic io_rd_stb,
    output logic [7:0] io_rdata,
    output logic io_rdata_valid,
    input wire logic parity_err_n,
    input wire logic iochk_n,
    input wire logic failsafe_out,
    input wire logic speaker_timer_out,
    input wire logic refresh_cycle,
    input wire logic bus_to_long,
    input wire logic bus_to_short,
    output logic speaker_gate,
    output logic speaker_out,
    output logic nmi_out,
    output logic bus_reset_drv,
    output logic [5:0] rtc_addr_ptr
);
    import nmiss_pkg::*;
    nmiss_src_if src ();
    logic [6:0] pins_sync;
    logic parity_lvl, iochk_lvl, fs_lvl, tmr_lvl, refresh_toggle_lvl, bt_long_lvl, bt_short_lvl;
    nmiss_sync #(.WIDTH(7)) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in({bus_to_short, bus_to_long, refresh_cycle, speaker_timer_out, failsafe_out,
            ~iochk_n, ~parity_err_n}),
        .sync_out(pins_sync)
    );
    assign {bt_short_lvl, bt_long_lvl, refresh_toggle_lvl, tmr_lvl, fs_lvl, iochk_lvl, parity_lvl} = pins_sync;

    typedef enum logic [1:0] {
        NMISS_RD_IDLE = 2'b01,
        NMISS_RD_DATA = 2'b10
    } nmiss_rd_e;
    nmiss_rd_e rd_state_reg, rd_state_next;

    logic [1:0] sc_ctl_reg, sc_ctl_next;       // gate, speaker data
    logic [1:0] sc_dis_reg, sc_dis_next;       // parity / io check disables
    logic [3:0] ex_ctl_reg, ex_ctl_next;       // bus reset, sw/fs/bt enables
    logic mask_reg, mask_next;
    logic [5:0] ptr_reg, ptr_next;
    logic refresh_toggle_reg, refresh_toggle_next;
    logic refresh_toggle_d_reg, fs_d_reg, bt_d_reg;
    logic refresh_toggle_d_next, fs_d_next, bt_d_next;
    logic [7:0] rdata_reg, rdata_next;
    logic nmi_reg, nmi_next;
    logic [7:0] sc_view, ex_view;
    logic any_pending;
    logic bt_lvl;

    function automatic logic port_hit(input logic [15:0] a, input logic [15:0] port);
        port_hit = (a == port);
    endfunction

    assign bt_lvl = bt_long_lvl | bt_short_lvl;
    // source events: fail-safe, timeout and trigger pulses; parity and io check pass as levels
    assign src.parity_evt = parity_lvl;
    assign src.iochk_evt = iochk_lvl;
    assign src.failsafe_evt = fs_lvl & ~fs_d_reg;
    assign src.bus_to_evt = bt_lvl & ~bt_d_reg;
    assign src.bus_to_short = bt_short_lvl;
    // any data byte counts as a trigger
    assign src.sw_evt = io_wr_stb && port_hit(io_addr, NMISS_PORT_SW_TRIGGER);
    assign src.sc_ctl = {4'h0, sc_dis_reg, sc_ctl_reg};
    assign src.ex_ctl = {4'h0, ex_ctl_reg};

    nmiss_latch_bank u_bank (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .src(src.bank)
    );

    always_comb begin
        sc_view = {src.parity_st, src.iochk_st, tmr_lvl, refresh_toggle_reg, sc_dis_reg[1], sc_dis_reg[0],
            sc_ctl_reg[1], sc_ctl_reg[0]};
        ex_view = {src.failsafe_st, src.bus_to_st, src.sw_st, src.bus_to_st & src.short_to,
            ex_ctl_reg};
        any_pending = src.parity_st | src.iochk_st | src.failsafe_st | src.bus_to_st | src.sw_st;
    end

    always_comb begin
        sc_ctl_next = sc_ctl_reg;
        sc_dis_next = sc_dis_reg;
        ex_ctl_next = ex_ctl_reg;
        mask_next = mask_reg;
        ptr_next = ptr_reg;
        refresh_toggle_next = refresh_toggle_reg ^ (refresh_toggle_lvl & ~refresh_toggle_d_reg);
        if (io_wr_stb) begin
            // read-only status bits are ignored on write
            if (port_hit(io_addr, NMISS_PORT_STATUS_CONTROL)) begin
                sc_ctl_next = io_wdata[1:0];
                sc_dis_next = io_wdata[3:2];
            end
            if (port_hit(io_addr, NMISS_PORT_EXT_STATUS)) begin
                ex_ctl_next = io_wdata[3:0];
            end
            if (port_hit(io_addr, NMISS_PORT_GLOBAL_MASK)) begin
                mask_next = io_wdata[NMISS_MASK_BIT];
                ptr_next = io_wdata[NMISS_RTC_PTR_W-1:0];
            end
        end
        // clean low while masked so unmasking gives a new rising edge
        nmi_next = any_pending & ~mask_reg;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sc_ctl_reg <= NMISS_SC_RESET[1:0];
            sc_dis_reg <= NMISS_SC_RESET[3:2];
            ex_ctl_reg <= NMISS_EX_RESET[3:0];
            mask_reg <= NMISS_MASK_RESET;
            ptr_reg <= NMISS_RTC_PTR_RESET;
            refresh_toggle_reg <= 1'b0;
            nmi_reg <= 1'b0;
        end else begin
            sc_ctl_reg <= sc_ctl_next;
            sc_dis_reg <= sc_dis_next;
            ex_ctl_reg <= ex_ctl_next;
            mask_reg <= mask_next;
            ptr_reg <= ptr_next;
            refresh_toggle_reg <= refresh_toggle_next;
            nmi_reg <= nmi_next;
        end
    end

    // pin history for the edge detectors; resets to the idle pin level so no false edge
    always_comb begin
        refresh_toggle_d_next = refresh_toggle_lvl;
        fs_d_next = fs_lvl;
        bt_d_next = bt_lvl;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            refresh_toggle_d_reg <= 1'b0;
            fs_d_reg <= 1'b0;
            bt_d_reg <= 1'b0;
        end else begin
            refresh_toggle_d_reg <= refresh_toggle_d_next;
            fs_d_reg <= fs_d_next;
            bt_d_reg <= bt_d_next;
        end
    end

    // read data captured at the strobe so it stands until the next read
    always_comb begin
        rdata_next = rdata_reg;
        rd_state_next = NMISS_RD_IDLE;
        if (io_rd_stb) begin
            rd_state_next = NMISS_RD_DATA;
            if (port_hit(io_addr, NMISS_PORT_STATUS_CONTROL)) rdata_next = sc_view;
            else if (port_hit(io_addr, NMISS_PORT_EXT_STATUS)) rdata_next = ex_view;
            else rdata_next = 8'h00;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
            rd_state_reg <= NMISS_RD_IDLE;
        end else begin
            rdata_reg <= rdata_next;
            rd_state_reg <= rd_state_next;
        end
    end

    always_comb begin
        case (rd_state_reg)
            NMISS_RD_IDLE: io_rdata_valid = 1'b0;
            NMISS_RD_DATA: io_rdata_valid = 1'b1;
            default: io_rdata_valid = 1'b0;
        endcase
    end

    assign io_rdata = rdata_reg;
    assign speaker_gate = sc_ctl_reg[NMISS_SC_GATE];
    assign speaker_out = sc_ctl_reg[NMISS_SC_SPEAKER_DATA] & tmr_lvl;
    assign nmi_out = nmi_reg;
    // the software bit is held by the host for the bus settle time
    assign bus_reset_drv = ex_ctl_reg[NMISS_EX_BUS_RESET] | src.bus_to_st;
    assign rtc_addr_ptr = ptr_reg;

    a_speaker_and: assert property (@(posedge sys_clk) disable iff (sys_rst)
        speaker_out == (sc_ctl_reg[1] & tmr_lvl))
        else $error("speaker output is not data and timer");
    a_speaker_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_wr_stb && port_hit(io_addr, NMISS_PORT_STATUS_CONTROL)
        |=> sc_ctl_reg[NMISS_SC_SPEAKER_DATA] == $past(io_wdata[NMISS_SC_SPEAKER_DATA]))
        else $error("speaker data bit not applied");
    a_mask_blocks: assert property (@(posedge sys_clk) disable iff (sys_rst)
        mask_reg |=> !nmi_out)
        else $error("nmi asserted while masked");
    a_mask_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_wr_stb && port_hit(io_addr, NMISS_PORT_GLOBAL_MASK) |=> mask_reg == $past(io_wdata[NMISS_MASK_BIT]))
        else $error("mask bit not written");
    a_nmi_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
        any_pending && !mask_reg |=> nmi_out)
        else $error("pending source gave no nmi");
    a_unmask_edge: assert property (@(posedge sys_clk) disable iff (sys_rst)
        mask_reg && !mask_next && any_pending ##1 any_pending |=> $rose(nmi_out))
        else $error("unmask gave no fresh edge");
    a_bus_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_wr_stb && port_hit(io_addr, NMISS_PORT_EXT_STATUS) && io_wdata[NMISS_EX_BUS_RESET] |=> bus_reset_drv)
        else $error("bus reset not driven");
    a_bt_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(src.bus_to_st) && !ex_ctl_reg[0] |-> !bus_reset_drv)
        else $error("bus reset held after timeout cleared");
    a_refresh_tgl: assert property (@(posedge sys_clk) disable iff (sys_rst)
        refresh_toggle_lvl && !refresh_toggle_d_reg |=> refresh_toggle_reg != $past(refresh_toggle_reg))
        else $error("refresh bit did not toggle");
    a_refresh_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd_stb && port_hit(io_addr, NMISS_PORT_STATUS_CONTROL) |=> io_rdata[NMISS_SC_REFRESH] == $past(refresh_toggle_reg))
        else $error("refresh bit read wrong");
    a_timer_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd_stb && port_hit(io_addr, NMISS_PORT_STATUS_CONTROL) |=> io_rdata[NMISS_SC_TIMER_OUT] == $past(tmr_lvl))
        else $error("timer bit read wrong");
    a_sw_trigger: assert property (@(posedge sys_clk) disable iff (sys_rst)
        src.sw_evt && ex_ctl_reg[1] && !mask_reg |=> ##1 nmi_out)
        else $error("trigger write gave no nmi");
    a_gate_out: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_wr_stb && port_hit(io_addr, NMISS_PORT_STATUS_CONTROL) |=> speaker_gate == $past(io_wdata[0]))
        else $error("gate bit not applied");
    a_parity_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        sc_dis_reg[0] |=> !src.parity_st)
        else $error("parity flag not cleared by disable");
    a_parity_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        src.parity_evt && !sc_dis_reg[0] |=> src.parity_st)
        else $error("parity error not latched");
    a_iochk_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        src.iochk_evt && !sc_dis_reg[1] |=> src.iochk_st)
        else $error("io check not latched");
    a_ext_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_wr_stb && port_hit(io_addr, NMISS_PORT_EXT_STATUS) |=> ex_ctl_reg == $past(io_wdata[3:0]))
        else $error("extended control bits not written");
    a_sw_disable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !ex_ctl_reg[NMISS_EX_SW_EN] |=> !src.sw_st)
        else $error("software flag set while port disabled");
    a_fs_disable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !ex_ctl_reg[NMISS_EX_FS_EN] |=> !src.failsafe_st)
        else $error("fail-safe flag set while disabled");
    a_bt_disable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !ex_ctl_reg[NMISS_EX_BT_EN] |=> !src.bus_to_st)
        else $error("timeout flag set while disabled");
    a_bt_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        src.bus_to_evt && ex_ctl_reg[NMISS_EX_BT_EN] |=> src.bus_to_st)
        else $error("bus timeout not latched");
    a_fs_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        src.failsafe_evt && ex_ctl_reg[NMISS_EX_FS_EN] |=> src.failsafe_st)
        else $error("fail-safe expiry not latched");
    a_fs_held: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !src.failsafe_st && fs_lvl && fs_d_reg |=> !src.failsafe_st)
        else $error("held fail-safe level set the flag again");
    a_short_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd_stb && port_hit(io_addr, NMISS_PORT_EXT_STATUS) && !src.bus_to_st
        |=> !io_rdata[NMISS_EX_SHORT_TO])
        else $error("short timeout bit read without timeout");
    a_ptr_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_wr_stb && port_hit(io_addr, NMISS_PORT_GLOBAL_MASK)
        |=> rtc_addr_ptr == $past(io_wdata[NMISS_RTC_PTR_W-1:0]))
        else $error("clock pointer not written");
    a_ptr_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !(io_wr_stb && port_hit(io_addr, NMISS_PORT_GLOBAL_MASK)) |=> $stable(rtc_addr_ptr))
        else $error("clock pointer changed without a write");
    a_valid_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd_stb |=> io_rdata_valid)
        else $error("read gave no valid pulse");
    a_valid_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !io_rd_stb |=> !io_rdata_valid)
        else $error("valid pulse without a read");
    a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd_stb && !port_hit(io_addr, NMISS_PORT_STATUS_CONTROL) && !port_hit(io_addr, NMISS_PORT_EXT_STATUS)
        |=> io_rdata == 8'h00)
        else $error("write-only or unmapped port read nonzero");
endmodule

// ### design/nmiss_pkg.sv
// nmiss_pkg: port addresses, bit positions and reset values of the nmi logic
// assumes a 16-bit i/o address and 8-bit data from the host cpu
package nmiss_pkg;
    localparam int NMISS_ADDR_W = 16;
    localparam logic [15:0] NMISS_PORT_STATUS_CONTROL = 16'h0061;
    localparam logic [15:0] NMISS_PORT_GLOBAL_MASK = 16'h0070;
    localparam logic [15:0] NMISS_PORT_EXT_STATUS = 16'h0461;
    localparam logic [15:0] NMISS_PORT_SW_TRIGGER = 16'h0462;
    // status/control port bits
    localparam int NMISS_SC_GATE = 0;
    localparam int NMISS_SC_SPEAKER_DATA = 1;
    localparam int NMISS_SC_PARITY_DIS = 2;
    localparam int NMISS_SC_IOCHK_DIS = 3;
    localparam int NMISS_SC_REFRESH = 4;
    localparam int NMISS_SC_TIMER_OUT = 5;
    localparam int NMISS_SC_IOCHK_ST = 6;
    localparam int NMISS_SC_PARITY_ST = 7;
    // extended port bits
    localparam int NMISS_EX_BUS_RESET = 0;
    localparam int NMISS_EX_SW_EN = 1;
    localparam int NMISS_EX_FS_EN = 2;
    localparam int NMISS_EX_BT_EN = 3;
    localparam int NMISS_EX_SHORT_TO = 4;
    localparam int NMISS_EX_SW_ST = 5;
    localparam int NMISS_EX_BT_ST = 6;
    localparam int NMISS_EX_FS_ST = 7;
    // mask port
    localparam int NMISS_MASK_BIT = 7;
    localparam int NMISS_RTC_PTR_W = 6;
    localparam logic [7:0] NMISS_SC_RESET = 8'h00;
    localparam logic [7:0] NMISS_EX_RESET = 8'h00;
    localparam logic NMISS_MASK_RESET = 1'b0;
    localparam logic [5:0] NMISS_RTC_PTR_RESET = 6'h00;
    localparam int NMISS_BUS_RESET_MIN_CYC = 8;
endpackage

// ### design/nmiss_src_if.sv
// nmiss_src_if: synchronised nmi source events between the top and the latch bank
// assumes all signals are on sys_clk
`timescale 1ns/10ps
interface nmiss_src_if;
    logic parity_evt;
    logic iochk_evt;
    logic failsafe_evt;
    logic bus_to_evt;
    logic bus_to_short;
    logic sw_evt;
    logic [7:0] sc_ctl;
    logic [7:0] ex_ctl;
    logic parity_st;
    logic iochk_st;
    logic failsafe_st;
    logic bus_to_st;
    logic sw_st;
    logic short_to;
    modport top (output parity_evt, iochk_evt, failsafe_evt, bus_to_evt, bus_to_short, sw_evt,
        sc_ctl, ex_ctl, input parity_st, iochk_st, failsafe_st, bus_to_st, sw_st, short_to);
    modport bank (input parity_evt, iochk_evt, failsafe_evt, bus_to_evt, bus_to_short, sw_evt,
        sc_ctl, ex_ctl, output parity_st, iochk_st, failsafe_st, bus_to_st, sw_st, short_to);
endinterface

// ### design/nmiss_sync.sv
// nmiss_sync: two-flop synchroniser for a bundle of pin levels
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/10ps
module nmiss_sync #(
    parameter int WIDTH = 4
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    initial begin
        if (WIDTH < 1) $error("nmiss_sync width must be positive");
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end
    assign sync_out = sync_reg;
endmodule

// ### design/nmiss_latch_bank.sv
// nmiss_latch_bank: sticky status bits for the five nmi sources
// assumes single-cycle fail-safe, timeout and trigger pulses, parity and io check levels, and control bytes from the register file
`timescale 1ns/10ps
module nmiss_latch_bank
    import nmiss_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    nmiss_src_if.bank src
);
    logic parity_st_reg, parity_st_next;
    logic iochk_st_reg, iochk_st_next;
    logic fs_st_reg, fs_st_next;
    logic bt_st_reg, bt_st_next;
    logic sw_st_reg, sw_st_next;
    logic short_reg, short_next;
    always_comb begin
        parity_st_next = parity_st_reg;
        iochk_st_next = iochk_st_reg;
        fs_st_next = fs_st_reg;
        bt_st_next = bt_st_reg;
        sw_st_next = sw_st_reg;
        short_next = short_reg;
        // disable-high controls hold the flag clear; enable-high controls hold it clear when low
        if (src.sc_ctl[NMISS_SC_PARITY_DIS]) parity_st_next = 1'b0;
        else if (src.parity_evt) parity_st_next = 1'b1;
        if (src.sc_ctl[NMISS_SC_IOCHK_DIS]) iochk_st_next = 1'b0;
        else if (src.iochk_evt) iochk_st_next = 1'b1;
        if (!src.ex_ctl[NMISS_EX_FS_EN]) fs_st_next = 1'b0;
        else if (src.failsafe_evt) fs_st_next = 1'b1;
        if (!src.ex_ctl[NMISS_EX_BT_EN]) begin
            bt_st_next = 1'b0;
            short_next = 1'b0;
        end else if (src.bus_to_evt) begin
            bt_st_next = 1'b1;
            short_next = src.bus_to_short;
        end
        if (!src.ex_ctl[NMISS_EX_SW_EN]) sw_st_next = 1'b0;
        else if (src.sw_evt) sw_st_next = 1'b1;
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            parity_st_reg <= 1'b0;
            iochk_st_reg <= 1'b0;
            fs_st_reg <= 1'b0;
            bt_st_reg <= 1'b0;
            sw_st_reg <= 1'b0;
            short_reg <= 1'b0;
        end else begin
            parity_st_reg <= parity_st_next;
            iochk_st_reg <= iochk_st_next;
            fs_st_reg <= fs_st_next;
            bt_st_reg <= bt_st_next;
            sw_st_reg <= sw_st_next;
            short_reg <= short_next;
        end
    end
    assign src.parity_st = parity_st_reg;
    assign src.iochk_st = iochk_st_reg;
    assign src.failsafe_st = fs_st_reg;
    assign src.bus_to_st = bt_st_reg;
    assign src.sw_st = sw_st_reg;
    assign src.short_to = short_reg;

    a_parity_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
        src.parity_evt && !src.sc_ctl[NMISS_SC_PARITY_DIS] |=> parity_st_reg)
        else $error("parity event not latched");
    a_iochk_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        src.sc_ctl[NMISS_SC_IOCHK_DIS] |=> !iochk_st_reg)
        else $error("io check flag not cleared by disable");
    a_sw_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        sw_st_reg && src.ex_ctl[NMISS_EX_SW_EN] |=> sw_st_reg)
        else $error("software flag dropped while enabled");
    a_short_type: assert property (@(posedge sys_clk) disable iff (sys_rst)
        src.bus_to_evt && src.ex_ctl[NMISS_EX_BT_EN] |=> short_reg == $past(src.bus_to_short))
        else $error("timeout type wrong");
endmodule

// ### dv/nmiss_host.sv
// nmiss_host: host cpu model issuing single-cycle i/o reads and writes
// assumes the bench calls its tasks; signals change on the falling edge
`timescale 1ns/10ps
module nmiss_host
    import nmiss_pkg::*;
(
    input wire logic sys_clk,
    output logic [nmiss_pkg::NMISS_ADDR_W-1:0] io_addr,
    output logic [7:0] io_wdata,
    output logic io_wr_stb,
    output logic io_rd_stb
);
    initial begin
        io_addr = 16'hffff;
        io_wdata = 8'h00;
        io_wr_stb = 1'b0;
        io_rd_stb = 1'b0;
    end
    // one strobe cycle; the edge between the two falling edges takes it
    task automatic xfer(input logic [15:0] a, input logic [7:0] d, input logic w);
        @(negedge sys_clk);
        io_addr = a;
        io_wdata = d;
        io_wr_stb = w;
        io_rd_stb = !w;
        @(negedge sys_clk);
        io_wr_stb = 1'b0;
        io_rd_stb = 1'b0;
        // released bus shows an inverted pattern, not the stale value
        io_addr = ~a;
        io_wdata = ~d;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        xfer(a, d, 1'b1);
    endtask
    task automatic rd(input logic [15:0] a);
        xfer(a, 8'h00, 1'b0);
    endtask
endmodule

// ### dv/testbench.sv
// testbench: drives the nmi block through a host model and its source pins
// assumes nmiss_pkg, nmiss_top and nmiss_host are compiled before it
`timescale 1ns/10ps
module testbench;
    import nmiss_pkg::*;
    logic sys_clk, sys_rst, io_wr_stb, io_rd_stb, io_rdata_valid;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, v;
    logic [5:0] rtc_addr_ptr;
    logic [2:0] ev;
    logic parity_err_n, iochk_n, tmr, refresh_toggle, speaker_gate, speaker_out, nmi_out, bus_reset_drv;
    logic [7:0] exp_q[$];
    int n_mismatch, n_compared, seed;
    localparam logic [15:0] SC = NMISS_PORT_STATUS_CONTROL;
    localparam logic [15:0] EX = NMISS_PORT_EXT_STATUS;

    nmiss_host i_nmiss_host (.sys_clk(sys_clk), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb));
    nmiss_top i_nmiss_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .parity_err_n(parity_err_n), .iochk_n(iochk_n), .failsafe_out(ev[2]), .speaker_timer_out(tmr),
        .refresh_cycle(refresh_toggle), .bus_to_long(ev[1]), .bus_to_short(ev[0]), .speaker_gate(speaker_gate),
        .speaker_out(speaker_out), .nmi_out(nmi_out), .bus_reset_drv(bus_reset_drv),
        .rtc_addr_ptr(rtc_addr_ptr));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        chk(what, {7'h00, e}, {7'h00, g});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_nmiss_host.wr(a, d);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_nmiss_host.rd(a);
    endtask
    task automatic print_verdict();
        if (exp_q.size() != 0) begin
            n_mismatch++;
            $display("Error io_rdata_valid expected %0d more reads seen none", exp_q.size());
        end
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // read data is settled by the falling edge of its valid cycle
    always @(negedge sys_clk) begin
        if (io_rdata_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("Error io_rdata expected none seen %h", io_rdata);
            end else begin
                chk("io_rdata", exp_q.pop_front(), io_rdata);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        seed = 4;
        sys_rst = 1'b1;
        {parity_err_n, iochk_n} = 2'b11;
        {tmr, refresh_toggle, ev} = 5'h00;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        rd(SC, NMISS_SC_RESET);
        rd(EX, NMISS_EX_RESET);
        rd(NMISS_PORT_GLOBAL_MASK, 8'h00);
        rd(16'h0123, 8'h00);
        // read-only bits written as ones must be ignored
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            wr(SC, {6'h3f, v[1:0]});
            tmr = v[2];
            cyc(4);
            chk_bit("speaker_gate", v[0], speaker_gate);
            chk_bit("speaker_out", v[1] & v[2], speaker_out);
            rd(SC, {2'b00, v[2], 3'b011, v[1:0]});
        end
        tmr = 1'b0;
        wr(SC, 8'h0c);
        refresh_toggle = 1'b1;
        cyc(3);
        refresh_toggle = 1'b0;
        cyc(4);
        rd(SC, 8'h1c);
        for (int k = 0; k < 2; k++) begin
            // disabled source with pin active: no flag
            wr(SC, 8'h0c);
            if (k == 0) parity_err_n = 1'b0; else iochk_n = 1'b0;
            cyc(6);
            chk_bit("nmi_out", 1'b0, nmi_out);
            rd(SC, 8'h1c);
            wr(SC, 8'h00);
            cyc(6);
            chk_bit("nmi_out", 1'b1, nmi_out);
            rd(SC, k ? 8'h50 : 8'h90);
            v = $random(seed);
            wr(NMISS_PORT_GLOBAL_MASK, {2'b10, v[5:0]});
            cyc(3);
            chk_bit("nmi_out", 1'b0, nmi_out);
            chk("rtc_addr_ptr", {2'b00, v[5:0]}, {2'b00, rtc_addr_ptr});
            wr(NMISS_PORT_GLOBAL_MASK, 8'h00);
            cyc(3);
            chk_bit("nmi_out", 1'b1, nmi_out);
            {parity_err_n, iochk_n} = 2'b11;
            cyc(4);
            wr(SC, k ? 8'h08 : 8'h04);
            wr(SC, 8'h00);
            cyc(4);
            chk_bit("nmi_out", 1'b0, nmi_out);
            rd(SC, 8'h10);
        end
        wr(EX, 8'h00);
        wr(NMISS_PORT_SW_TRIGGER, 8'h5a);
        ev = 3'h7;
        cyc(6);
        chk_bit("nmi_out", 1'b0, nmi_out);
        ev = 3'h0;
        wr(EX, 8'h02);
        wr(NMISS_PORT_SW_TRIGGER, $random(seed));
        cyc(2);
        chk_bit("nmi_out", 1'b1, nmi_out);
        rd(EX, 8'h22);
        wr(EX, 8'h00);
        wr(EX, 8'h02);
        cyc(3);
        chk_bit("nmi_out", 1'b0, nmi_out);
        rd(EX, 8'h02);
        for (int j = 0; j < 3; j++) begin
            v = (j == 2) ? 8'h04 : 8'h08;
            wr(EX, v);
            ev[j] = 1'b1;
            cyc(6);
            chk_bit("nmi_out", 1'b1, nmi_out);
            chk_bit("bus_reset_drv", j != 2, bus_reset_drv);
            rd(EX, (j == 2) ? 8'h84 : {3'b010, j == 0, 4'h8});
            // clear while the source stays high: edge capture must not re-set
            wr(EX, 8'h00);
            wr(EX, v);
            cyc(4);
            chk_bit("nmi_out", 1'b0, nmi_out);
            chk_bit("bus_reset_drv", 1'b0, bus_reset_drv);
            ev[j] = 1'b0;
            rd(EX, v);
        end
        wr(EX, 8'h01);
        cyc(2);
        chk_bit("bus_reset_drv", 1'b1, bus_reset_drv);
        cyc(NMISS_BUS_RESET_MIN_CYC);
        wr(EX, 8'h00);
        cyc(2);
        chk_bit("bus_reset_drv", 1'b0, bus_reset_drv);
        rd(EX, 8'h00);
        cyc(4);
        print_verdict();
    end
endmodule
